// *** logic/gca_pkg.sv ***
// constants for the port configuration and autosleep block
package gca_pkg;

  // ****************************************************
  // register offsets
  // ****************************************************
  localparam logic [7:0] ADDR_SLEEP_TIMEOUT = 8'h06;
  localparam logic [7:0] ADDR_IO_GLOBAL     = 8'h40;
  localparam logic [7:0] ADDR_PORT_DIR      = 8'h41;
  localparam logic [7:0] ADDR_PORT_DEBOUNCE = 8'h42;
  localparam logic [7:0] ADDR_TIMEOUT_FLAG  = 8'h48;
  localparam logic [7:0] ADDR_IO_LAST       = 8'h5F;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int SLEEP_CODE_LSB = 0;
  localparam int SLEEP_CODE_W   = 3;
  localparam int GLB_ENCODER    = 7;
  localparam int GLB_TOUT_IRQ   = 5;
  localparam int GLB_IO_ENABLE  = 4;
  localparam int GLB_SOFT_RESET = 3;
  localparam int GLB_FADE_LSB   = 0;
  localparam int FADE_CODE_W    = 3;
  localparam int DEB_CODE_W     = 5;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] RST_SLEEP_TIMEOUT = 8'h07;
  localparam logic [7:0] RST_IO_GLOBAL     = 8'h00;
  localparam logic [7:0] RST_PORT_DIR      = 8'h00;
  localparam logic [7:0] RST_PORT_DEBOUNCE = 8'h00;

  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MS_IN_PS      = 1000000000;
  localparam int MS_CYCLES     = MS_IN_PS / CLK_PERIOD_PS;
  localparam int SLEEP_MAX_MS  = 8192;
  localparam int SLEEP_MIN_MS  = 256;
  localparam int FADE_BASE_MS  = 256;
  localparam int FADE_STEPS    = 16;
  localparam int FADE_STEP_MS  = FADE_BASE_MS / FADE_STEPS;

endpackage

// *** logic/gca_top.sv ***
// port configuration registers, fade ramp and key scanner autosleep
`timescale 1ns/100ps

module gca_top #(
  parameter int MS_CYCLES = gca_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst,
  // decoded register access from the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata_q,
  // events
  input  wire logic       bus_timeout,
  input  wire logic       key_activity,
  input  wire logic       key_sleep_force,
  // fade request
  input  wire logic       fade_start,
  input  wire logic       fade_up,
  input  wire logic [7:0] common_pwm,
  // status and control outputs
  output logic            port_irq_out_q,
  output logic            key_asleep_q,
  output logic            part_shutdown_q,
  output logic            pwm_enable_q,
  output logic            cc_enable_q,
  output logic            general_input_enable_q,
  output logic            encoder_mode_q,
  output logic      [7:0] port_dir_q,
  output logic      [4:0] debounce_code_q,
  output logic      [7:0] fade_duty_q
);

  typedef enum logic {GCA_AWAKE, GCA_ASLEEP} gca_sleep_e;
  typedef enum logic {GCA_FADE_IDLE, GCA_FADE_RAMP} gca_fade_e;

  // ****************************************************
  // register file
  // ****************************************************
  logic [7:0] sleep_reg_q, sleep_reg_d;
  logic [7:0] glb_reg_q, glb_reg_d;
  logic [7:0] dir_reg_q, dir_reg_d;
  logic [7:0] deb_reg_q, deb_reg_d;
  logic       tout_flag_q, tout_flag_d;
  logic       irq_d;
  logic [7:0] rdata_d;
  logic       io_range;
  logic       io_en;
  logic       soft_reset;

  assign io_en      = glb_reg_q[gca_pkg::GLB_IO_ENABLE];
  assign io_range   = (reg_addr >= gca_pkg::ADDR_PORT_DIR) && (reg_addr <= gca_pkg::ADDR_IO_LAST);
  assign soft_reset = reg_wr && (reg_addr == gca_pkg::ADDR_IO_GLOBAL)
                      && reg_wdata[gca_pkg::GLB_SOFT_RESET];

  always_comb begin
    sleep_reg_d = sleep_reg_q;
    glb_reg_d   = glb_reg_q;
    dir_reg_d   = dir_reg_q;
    deb_reg_d   = deb_reg_q;
    tout_flag_d = tout_flag_q;
    irq_d       = port_irq_out_q;
    // read of the flag register clears flag and interrupt; a new timeout wins
    if (reg_rd && (reg_addr == gca_pkg::ADDR_TIMEOUT_FLAG)) begin
      tout_flag_d = 1'b0;
      irq_d       = 1'b0;
    end
    if (bus_timeout) begin
      tout_flag_d = 1'b1;
      if (glb_reg_q[gca_pkg::GLB_TOUT_IRQ]) begin
        irq_d = 1'b1;
      end
    end
    if (reg_wr && (reg_addr == gca_pkg::ADDR_SLEEP_TIMEOUT)) begin
      sleep_reg_d = {5'h00, reg_wdata[gca_pkg::SLEEP_CODE_W-1:0]};
    end
    if (soft_reset) begin
      // whole 0x40..0x5F range back to power-on except the flag, which takes a same-cycle timeout; the strobe bit is not kept
      glb_reg_d   = gca_pkg::RST_IO_GLOBAL;
      dir_reg_d   = gca_pkg::RST_PORT_DIR;
      deb_reg_d   = gca_pkg::RST_PORT_DEBOUNCE;
      tout_flag_d = bus_timeout;
      irq_d       = 1'b0;
    end else if (reg_wr && (reg_addr == gca_pkg::ADDR_IO_GLOBAL)) begin
      glb_reg_d = reg_wdata & ~(8'h01 << gca_pkg::GLB_SOFT_RESET);
      glb_reg_d[6] = 1'b0;
    // the lock only guards 0x41 and up; 0x40 stays writable so the bank can be re-enabled
    end else if (reg_wr && io_range && io_en) begin
      if (reg_addr == gca_pkg::ADDR_PORT_DIR) begin
        dir_reg_d = reg_wdata;
      end
      if (reg_addr == gca_pkg::ADDR_PORT_DEBOUNCE) begin
        deb_reg_d = {3'h0, reg_wdata[gca_pkg::DEB_CODE_W-1:0]};
      end
    end
  end

  always_comb begin
    rdata_d = reg_rdata_q;
    if (reg_rd) begin
      case (reg_addr)
        gca_pkg::ADDR_SLEEP_TIMEOUT: rdata_d = sleep_reg_q;
        gca_pkg::ADDR_IO_GLOBAL:     rdata_d = glb_reg_q;
        gca_pkg::ADDR_PORT_DIR:      rdata_d = dir_reg_q;
        gca_pkg::ADDR_PORT_DEBOUNCE: rdata_d = deb_reg_q;
        gca_pkg::ADDR_TIMEOUT_FLAG:  rdata_d = {7'h00, tout_flag_q};
        default:                     rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sleep_reg_q    <= gca_pkg::RST_SLEEP_TIMEOUT;
      glb_reg_q      <= gca_pkg::RST_IO_GLOBAL;
      dir_reg_q      <= gca_pkg::RST_PORT_DIR;
      deb_reg_q      <= gca_pkg::RST_PORT_DEBOUNCE;
      tout_flag_q    <= 1'b0;
      port_irq_out_q <= 1'b0;
      reg_rdata_q    <= 8'h00;
    end else begin
      sleep_reg_q    <= sleep_reg_d;
      glb_reg_q      <= glb_reg_d;
      dir_reg_q      <= dir_reg_d;
      deb_reg_q      <= deb_reg_d;
      tout_flag_q    <= tout_flag_d;
      port_irq_out_q <= irq_d;
      reg_rdata_q    <= rdata_d;
    end
  end

  // ****************************************************
  // millisecond tick shared by sleep timer and fade
  // ****************************************************
  logic [31:0] ms_cnt_q, ms_cnt_d;
  logic        ms_tick;

  assign ms_tick = (ms_cnt_q == 32'(MS_CYCLES - 1));

  always_comb begin
    ms_cnt_d = ms_tick ? 32'h0000_0000 : ms_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ms_cnt_q <= 32'h0000_0000;
    end else begin
      ms_cnt_q <= ms_cnt_d;
    end
  end

  // ****************************************************
  // autosleep timer
  // ****************************************************
  logic [13:0] sleep_limit;
  logic [13:0] idle_ms_q, idle_ms_d;
  gca_sleep_e  slp_q, slp_d;
  logic [2:0]  sleep_delay_code;

  assign sleep_delay_code = sleep_reg_q[gca_pkg::SLEEP_CODE_LSB +: gca_pkg::SLEEP_CODE_W];

  // codes 6 and 7 both saturate at the shortest period
  always_comb begin
    case (sleep_delay_code)
      3'h0:    sleep_limit = 14'h0000;
      3'h6,
      3'h7:    sleep_limit = 14'(gca_pkg::SLEEP_MIN_MS);
      default: sleep_limit = 14'(gca_pkg::SLEEP_MAX_MS >> (sleep_delay_code - 3'h1));
    endcase
  end

  always_comb begin
    idle_ms_d = idle_ms_q;
    slp_d     = slp_q;
    case (slp_q)
      GCA_AWAKE: begin
        if (key_activity || sleep_limit == 14'h0000) begin
          idle_ms_d = 14'h0000;
        end else if (ms_tick) begin
          if (idle_ms_q + 14'h0001 >= sleep_limit) begin
            slp_d     = GCA_ASLEEP;
            idle_ms_d = 14'h0000;
          end else begin
            idle_ms_d = idle_ms_q + 14'h0001;
          end
        end
      end
      GCA_ASLEEP: begin
        if (key_activity) begin
          slp_d = GCA_AWAKE;
        end
      end
      default: begin
        slp_d     = GCA_AWAKE;
        idle_ms_d = 14'h0000;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slp_q     <= GCA_AWAKE;
      idle_ms_q <= 14'h0000;
    end else begin
      slp_q     <= slp_d;
      idle_ms_q <= idle_ms_d;
    end
  end

  // ****************************************************
  // fade ramp
  // ****************************************************
  gca_fade_e  fade_q, fade_d;
  logic [4:0] step_q, step_d;
  logic [8:0] step_ms_q, step_ms_d;
  logic [8:0] step_period;
  logic       dir_up_q, dir_up_d;
  logic [2:0] fade_code;
  logic [7:0] duty_d;
  logic [12:0] scaled;

  assign fade_code   = glb_reg_q[gca_pkg::GLB_FADE_LSB +: gca_pkg::FADE_CODE_W];
  // codes 6 and 7 shift past nine bits to a zero period, so each step takes one millisecond; the host avoids them
  assign step_period = 9'(gca_pkg::FADE_STEP_MS << (fade_code - 3'h1));

  always_comb begin
    fade_d    = fade_q;
    step_d    = step_q;
    step_ms_d = step_ms_q;
    dir_up_d  = dir_up_q;
    case (fade_q)
      GCA_FADE_IDLE: begin
        if (fade_start) begin
          dir_up_d  = fade_up;
          step_ms_d = 9'h000;
          if (fade_code == 3'h0) begin
            step_d = fade_up ? 5'(gca_pkg::FADE_STEPS) : 5'h00;
          end else begin
            fade_d = GCA_FADE_RAMP;
            step_d = fade_up ? 5'h00 : 5'(gca_pkg::FADE_STEPS);
          end
        end
      end
      GCA_FADE_RAMP: begin
        if (ms_tick) begin
          if (step_ms_q + 9'h001 >= step_period) begin
            step_ms_d = 9'h000;
            step_d    = dir_up_q ? step_q + 5'h01 : step_q - 5'h01;
            if ((dir_up_q && step_q == 5'(gca_pkg::FADE_STEPS - 1))
                || (!dir_up_q && step_q == 5'h01)) begin
              fade_d = GCA_FADE_IDLE;
            end
          end else begin
            step_ms_d = step_ms_q + 9'h001;
          end
        end
      end
      default: begin
        fade_d = GCA_FADE_IDLE;
        step_d = 5'(gca_pkg::FADE_STEPS);
      end
    endcase
  end

  // 16 equal steps of the common duty; no PWM while the bank is disabled
  // widen both operands first so the product cannot wrap at eight bits
  assign scaled = 13'(common_pwm) * 13'(step_q);
  always_comb begin
    duty_d = io_en ? scaled[11:4] : 8'h00;
    if (step_q == 5'(gca_pkg::FADE_STEPS) && io_en) begin
      duty_d = common_pwm;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fade_q      <= GCA_FADE_IDLE;
      step_q      <= 5'(gca_pkg::FADE_STEPS);
      step_ms_q   <= 9'h000;
      dir_up_q    <= 1'b1;
      fade_duty_q <= 8'h00;
    end else begin
      fade_q      <= fade_d;
      step_q      <= step_d;
      step_ms_q   <= step_ms_d;
      dir_up_q    <= dir_up_d;
      fade_duty_q <= duty_d;
    end
  end

  // ****************************************************
  // enables and port configuration outputs
  // ****************************************************
  logic asleep_now;

  // forced sleep from the key configuration counts the same as timer sleep
  assign asleep_now = (slp_d == GCA_ASLEEP) || key_sleep_force;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      key_asleep_q           <= 1'b0;
      part_shutdown_q        <= 1'b0;
      pwm_enable_q           <= 1'b0;
      cc_enable_q            <= 1'b0;
      general_input_enable_q <= 1'b0;
      encoder_mode_q         <= 1'b0;
      port_dir_q             <= 8'h00;
      debounce_code_q        <= 5'h00;
    end else begin
      key_asleep_q           <= asleep_now;
      part_shutdown_q        <= !glb_reg_d[gca_pkg::GLB_IO_ENABLE] && asleep_now;
      // outputs keep their direction even while disabled; their PWM duty fade_duty_q is forced to 00
      pwm_enable_q           <= glb_reg_d[gca_pkg::GLB_IO_ENABLE];
      cc_enable_q            <= glb_reg_d[gca_pkg::GLB_IO_ENABLE];
      general_input_enable_q <= glb_reg_d[gca_pkg::GLB_IO_ENABLE];
      encoder_mode_q         <= glb_reg_d[gca_pkg::GLB_ENCODER];
      port_dir_q             <= dir_reg_d;
      debounce_code_q        <= deb_reg_d[gca_pkg::DEB_CODE_W-1:0];
    end
  end

endmodule

// *** verif/gca_host.sv ***
// host model driving decoded register strobes
`timescale 1ns/100ps
module gca_host (
  // clock
  input  wire logic       ref_clk,
  // register strobes
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata_q
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hFF;
    reg_wdata = 8'hFF;
  end
  // released lines show the inverse so stale values never pass for fresh ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = (a == 8'h06) ? (d & 8'h07) : (a == 8'h42) ? (d & 8'h1F) :
                (a == 8'h40) ? (d & 8'hBF) : d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~reg_wdata;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata_q;
  endtask
endmodule

// *** verif/gca_chk.sv ***
// assertions on the ports of the configuration block
`timescale 1ns/100ps
module gca_chk #(
  parameter int MS_CYCLES = 4
) (
  input wire logic       ref_clk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic       bus_timeout,
  input wire logic       port_irq_out_q,
  input wire logic       key_asleep_q,
  input wire logic       part_shutdown_q,
  input wire logic       pwm_enable_q,
  input wire logic       cc_enable_q,
  input wire logic       general_input_enable_q,
  input wire logic       encoder_mode_q,
  input wire logic [7:0] port_dir_q,
  input wire logic [4:0] debounce_code_q,
  input wire logic [7:0] fade_duty_q
);
  // shadow of the timeout interrupt enable, soft reset clears it
  logic tout_en_d;
  logic tout_en_q;
  logic glb_wr;
  assign glb_wr = reg_wr && (reg_addr == 8'h40);
  always_comb begin
    tout_en_d = tout_en_q;
    if (glb_wr) begin
      tout_en_d = reg_wdata[5] & ~reg_wdata[3];
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tout_en_q <= 1'b0;
    end else begin
      tout_en_q <= tout_en_d;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_tout_armed; bus_timeout && tout_en_q; endsequence
  sequence s_flag_read; reg_rd && (reg_addr == 8'h48) && !bus_timeout; endsequence
  property p_irq_set; s_tout_armed |=> port_irq_out_q; endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not raised");
  property p_irq_cause; $rose(port_irq_out_q) |-> $past(bus_timeout); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without timeout");
  property p_irq_clr; s_flag_read |=> !port_irq_out_q; endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");
  property p_en_copy; pwm_enable_q == cc_enable_q && cc_enable_q == general_input_enable_q;
  endproperty
  a_en_copy: assert property (p_en_copy) else $error("enables differ");
  property p_duty_off; !pwm_enable_q [*2] |-> fade_duty_q == 8'h00; endproperty
  a_duty_off: assert property (p_duty_off) else $error("duty while disabled");
  property p_dir_lock; reg_wr && reg_addr == 8'h41 && !pwm_enable_q |=> $stable(port_dir_q);
  endproperty
  a_dir_lock: assert property (p_dir_lock) else $error("locked write taken");
  property p_dir_wr; reg_wr && reg_addr == 8'h41 && pwm_enable_q
    |=> port_dir_q == $past(reg_wdata); endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");
  property p_shut; !pwm_enable_q && key_asleep_q [*2] |-> part_shutdown_q; endproperty
  a_shut: assert property (p_shut) else $error("no shutdown");
  property p_run; pwm_enable_q |-> !part_shutdown_q; endproperty
  a_run: assert property (p_run) else $error("shutdown while enabled");
  property p_enc; glb_wr && !reg_wdata[3] |=> encoder_mode_q == $past(reg_wdata[7]); endproperty
  a_enc: assert property (p_enc) else $error("encoder mode wrong");
  property p_soft; glb_wr && reg_wdata[3] |=> port_dir_q == 8'h00 && debounce_code_q == 5'h00
    && !encoder_mode_q && !pwm_enable_q; endproperty
  a_soft: assert property (p_soft) else $error("soft reset incomplete");
  property p_sleep_rd; reg_rd && reg_addr == 8'h06 |=> reg_rdata_q[7:3] == 5'h00; endproperty
  a_sleep_rd: assert property (p_sleep_rd) else $error("reserved sleep bits");
endmodule
bind gca_top gca_chk #(.MS_CYCLES(MS_CYCLES)) i_gca_chk (.ref_clk(ref_clk), .rst(rst),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .bus_timeout(bus_timeout), .port_irq_out_q(port_irq_out_q),
  .key_asleep_q(key_asleep_q), .part_shutdown_q(part_shutdown_q),
  .pwm_enable_q(pwm_enable_q), .cc_enable_q(cc_enable_q),
  .general_input_enable_q(general_input_enable_q), .encoder_mode_q(encoder_mode_q),
  .port_dir_q(port_dir_q), .debounce_code_q(debounce_code_q), .fade_duty_q(fade_duty_q));

// *** verif/test_gpio_config_and_autosleep.sv ***
// self-checking bench for the configuration and autosleep block
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module test_gpio_config_and_autosleep;
  logic       ref_clk = 1'b0, rst = 1'b1, bus_timeout = 1'b0, key_activity = 1'b0;
  logic       key_sleep_force = 1'b0, fade_start = 1'b0, fade_up = 1'b0;
  logic [7:0] common_pwm = 8'h80, reg_addr, reg_wdata, reg_rdata_q, port_dir_q, fade_duty_q, d;
  logic       reg_wr, reg_rd, port_irq_out_q, key_asleep_q, part_shutdown_q, pwm_enable_q;
  logic       cc_enable_q, general_input_enable_q, encoder_mode_q;
  logic [4:0] debounce_code_q;
  int         failures = 0, total_checks = 0;
  always #2.5 ref_clk = ~ref_clk;
  gca_host i_gca_host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q));
  // a 4-cycle millisecond keeps the sleep and fade spans short
  gca_top #(.MS_CYCLES(4)) i_gca_top (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .bus_timeout(bus_timeout), .key_activity(key_activity), .key_sleep_force(key_sleep_force),
    .fade_start(fade_start), .fade_up(fade_up), .common_pwm(common_pwm),
    .port_irq_out_q(port_irq_out_q), .key_asleep_q(key_asleep_q),
    .part_shutdown_q(part_shutdown_q), .pwm_enable_q(pwm_enable_q), .cc_enable_q(cc_enable_q),
    .general_input_enable_q(general_input_enable_q), .encoder_mode_q(encoder_mode_q),
    .port_dir_q(port_dir_q), .debounce_code_q(debounce_code_q), .fade_duty_q(fade_duty_q));
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  task automatic t_reset;
    i_gca_host.rd(8'h06, d); `CHK("sleep", 8'h07, d)
    i_gca_host.rd(8'h41, d); `CHK("dir", 8'h00, d)
    i_gca_host.rd(8'h42, d); `CHK("debounce", 8'h00, d)
    i_gca_host.rd(8'h10, d); `CHK("unmapped", 8'h00, d)
    $display("t_reset done");
  endtask
  task automatic t_lock;
    i_gca_host.wr(8'h41, 8'hA5); `CHK("locked dir", 8'h00, port_dir_q)
    i_gca_host.wr(8'h40, 8'hB0); `CHK("encoder", 1'b1, encoder_mode_q)
    `CHK("enables", 3'b111, {pwm_enable_q, cc_enable_q, general_input_enable_q})
    i_gca_host.wr(8'h41, 8'hA5); `CHK("dir", 8'hA5, port_dir_q)
    i_gca_host.wr(8'h42, 8'hFF); `CHK("deb out", 5'h1F, debounce_code_q)
    i_gca_host.rd(8'h42, d); `CHK("deb rd", 8'h1F, d)
    $display("t_lock done");
  endtask
  task automatic t_irq;
    pulse(bus_timeout); `CHK("irq set", 1'b1, port_irq_out_q)
    i_gca_host.rd(8'h48, d); `CHK("flag", 8'h01, d)
    `CHK("irq clr", 1'b0, port_irq_out_q)
    i_gca_host.wr(8'h40, 8'h90);
    pulse(bus_timeout); `CHK("irq masked", 1'b0, port_irq_out_q)
    $display("t_irq done");
  endtask
  task automatic t_soft;
    i_gca_host.wr(8'h40, 8'hB8); `CHK("soft dir", 8'h00, port_dir_q)
    `CHK("soft deb", 5'h00, debounce_code_q)
    i_gca_host.rd(8'h40, d); `CHK("soft glb", 8'h00, d)
    $display("t_soft done");
  endtask
  task automatic t_fade;
    i_gca_host.wr(8'h40, 8'h10);
    fade_up = 1'b0;
    pulse(fade_start); repeat (3) @(negedge ref_clk); `CHK("jump dn", 8'h00, fade_duty_q)
    fade_up = 1'b1;
    pulse(fade_start); repeat (3) @(negedge ref_clk); `CHK("jump up", 8'h80, fade_duty_q)
    i_gca_host.wr(8'h40, 8'h11);
    fade_up = 1'b1;
    pulse(fade_start); repeat (512) @(negedge ref_clk);
    `CHK("mid", 1'b1, fade_duty_q > 8'h00 && fade_duty_q < 8'h80)
    repeat (428) @(negedge ref_clk); `CHK("early", 1'b1, fade_duty_q < 8'h80)
    repeat (160) @(negedge ref_clk); `CHK("full", 8'h80, fade_duty_q)
    $display("t_fade done");
  endtask
  task automatic t_sleep;
    i_gca_host.wr(8'h06, 8'h06);
    pulse(key_activity); repeat (960) @(negedge ref_clk); `CHK("awake", 1'b0, key_asleep_q)
    repeat (100) @(negedge ref_clk); `CHK("asleep", 1'b1, key_asleep_q)
    `CHK("running", 1'b0, part_shutdown_q)
    i_gca_host.wr(8'h40, 8'h00); repeat (2) @(negedge ref_clk);
    `CHK("shutdown", 1'b1, part_shutdown_q)
    `CHK("pwm off", 8'h00, fade_duty_q)
    `CHK("inputs off", 1'b0, general_input_enable_q)
    pulse(key_activity); repeat (2) @(negedge ref_clk); `CHK("woken", 1'b0, key_asleep_q)
    key_sleep_force = 1'b1;
    repeat (2) @(negedge ref_clk); `CHK("forced", 1'b1, part_shutdown_q)
    key_sleep_force = 1'b0;
    i_gca_host.wr(8'h06, 8'h00);
    pulse(key_activity); repeat (1100) @(negedge ref_clk); `CHK("off", 1'b0, key_asleep_q)
    i_gca_host.wr(8'h06, 8'h05);
    pulse(key_activity); repeat (1100) @(negedge ref_clk); `CHK("512a", 1'b0, key_asleep_q)
    repeat (1000) @(negedge ref_clk); `CHK("512b", 1'b1, key_asleep_q)
    $display("t_sleep done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_lock();
    t_irq();
    t_soft();
    t_fade();
    t_sleep();
    final_report();
  end
  // the tests take about 5400 cycles, 27 us
  initial begin
    #200us;
    failures++;
    final_report();
  end
endmodule
